//--- verilog/fns_pkg.sv
package fns_pkg;
   // ==========================================
   // register offsets (register port index)
   localparam logic [4:0] FNS_OFF_REF_DIV = 5'h02;
   localparam logic [4:0] FNS_OFF_INT_DIV = 5'h03;
   localparam logic [4:0] FNS_OFF_FRAC_DIV = 5'h04;
   localparam logic [4:0] FNS_OFF_OSC_PORT = 5'h05;
   localparam logic [4:0] FNS_OFF_MOD_CFG = 5'h06;

   // ==========================================
   // reset values
   localparam logic [13:0] FNS_RST_REF_DIV = 14'h0001;
   localparam logic [18:0] FNS_RST_INT_DIV = 19'h00019;
   localparam logic [23:0] FNS_RST_FRAC_DIV = 24'h000000;
   localparam logic [15:0] FNS_RST_OSC_PORT = 16'h0000;
   localparam logic [22:0] FNS_RST_MOD_CFG = 23'h200b4a;

   // ==========================================
   // oscillator port fields
   localparam int FNS_PKT_W = 16;
   localparam int FNS_PORT_ID_LSB = 0;
   localparam int FNS_PORT_IDX_LSB = 3;
   localparam int FNS_PORT_DATA_LSB = 7;
   localparam int FNS_PORT_DATA_MSB = 15;

   // ==========================================
   // modulator configuration fields
   localparam int FNS_CFG_SEED_LSB = 0;
   localparam int FNS_CFG_ORDER_LSB = 2;
   localparam int FNS_CFG_BYPASS = 7;
   localparam int FNS_CFG_RELOAD = 8;
   localparam int FNS_CFG_CLK_SRC = 9;
   localparam int FNS_CFG_CLK_DLY = 10;
   localparam int FNS_CFG_CORE_EN = 11;
   localparam int FNS_CFG_BIST_EN = 18;
   localparam int FNS_CFG_BIST_LSB = 19;
   localparam int FNS_CFG_AUTO_CLK = 21;

   // ==========================================
   // start values and self-test lengths
   localparam logic [23:0] FNS_SEED_ZERO = 24'h000000;
   localparam logic [23:0] FNS_SEED_LSB = 24'h000001;
   localparam logic [23:0] FNS_SEED_A = 24'hb29d08;
   localparam logic [23:0] FNS_SEED_B = 24'h50f1cd;
   localparam logic [11:0] FNS_BIST_C0 = 12'h408;
   localparam logic [11:0] FNS_BIST_C1 = 12'h7ff;
   localparam logic [11:0] FNS_BIST_C2 = 12'hbff;
   localparam logic [11:0] FNS_BIST_C3 = 12'hfff;

   // ==========================================
   // link timing
   localparam int FNS_CLK_MHZ = 40;
   localparam int FNS_LINK_MAX_MHZ = 50;
   localparam int FNS_LINK_HALF = (FNS_CLK_MHZ + 2 * FNS_LINK_MAX_MHZ - 1) / (2 * FNS_LINK_MAX_MHZ);

   // ==========================================
   // types
   typedef enum logic [1:0] {
      FNS_ORD_FIRST = 2'h0,
      FNS_ORD_SECOND = 2'h1,
      FNS_ORD_T1_B = 2'h2,
      FNS_ORD_T2_A = 2'h3
   } fns_order_e;

   typedef enum logic [1:0] {
      FNS_CLK_REF = 2'h0,
      FNS_CLK_OSC = 2'h1,
      FNS_CLK_OVERRIDE = 2'h2
   } fns_clksrc_e;

   typedef enum logic [2:0] {
      FNS_LK_IDLE = 3'h1,
      FNS_LK_LOW = 3'h2,
      FNS_LK_HIGH = 3'h4
   } fns_link_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [23:0] wdata;
   } fns_req_s;

   typedef struct packed {
      logic sclk;
      logic sdata;
      logic frame;
   } fns_link_s;

   typedef struct packed {
      logic [23:0] start_value;
      logic start_load;
      fns_order_e order;
      logic bypass;
      fns_clksrc_e clk_src;
      logic clk_delay;
      logic core_enable;
      logic self_test_start;
      logic [11:0] self_test_cycles;
   } fns_mod_s;
endpackage : fns_pkg

//--- verilog/fns_osc_link.sv
`timescale 1ns/100ps
module fns_osc_link import fns_pkg::*; (
   input logic clk,
   input logic rst_n,
   input logic ce,
   input logic start,
   input logic [15:0] packet,
   output logic busy,
   output fns_link_s link
);
   // ==========================================
   // state
   typedef struct packed {
      fns_link_state_e state;
      logic [15:0] shreg;
      logic [3:0] bitcnt;
      logic [3:0] cnt;
      fns_link_s link;
   } fns_lk_s;

   localparam logic [3:0] HALF_M1 = 4'(FNS_LINK_HALF - 1);
   localparam fns_lk_s LK_INIT = '{state: FNS_LK_IDLE, shreg: 16'h0000, bitcnt: 4'h0,
                                   cnt: 4'h0, link: 3'h0};
   fns_lk_s lk_reg;
   fns_lk_s lk_next;

   assign busy = (lk_reg.state != FNS_LK_IDLE);
   assign link = lk_reg.link;

   // ==========================================
   // serializer: data changes with sclk low, the far end samples on the rise
   always_comb begin
      lk_next = lk_reg;
      case (lk_reg.state)
         FNS_LK_IDLE: begin
            lk_next.link = 3'h0;
            if (start) begin
               lk_next.shreg = packet;
               lk_next.bitcnt = 4'hf;
               lk_next.cnt = HALF_M1; // RL18
               lk_next.link.frame = 1'b1;
               lk_next.link.sdata = packet[15]; // RL17
               lk_next.state = FNS_LK_LOW;
            end
         end
         FNS_LK_LOW: begin
            if (lk_reg.cnt == 4'h0) begin
               lk_next.link.sclk = 1'b1;
               lk_next.cnt = HALF_M1;
               lk_next.state = FNS_LK_HIGH;
            end else begin
               lk_next.cnt = lk_reg.cnt - 4'h1;
            end
         end
         FNS_LK_HIGH: begin
            if (lk_reg.cnt != 4'h0) begin
               lk_next.cnt = lk_reg.cnt - 4'h1;
            end else if (lk_reg.bitcnt == 4'h0) begin
               lk_next.link = 3'h0;
               lk_next.state = FNS_LK_IDLE;
            end else begin
               lk_next.bitcnt = lk_reg.bitcnt - 4'h1;
               lk_next.shreg = {lk_reg.shreg[14:0], 1'b0};
               lk_next.link.sdata = lk_reg.shreg[14]; // RL17
               lk_next.link.sclk = 1'b0;
               lk_next.cnt = HALF_M1;
               lk_next.state = FNS_LK_LOW;
            end
         end
         default: begin
            lk_next = LK_INIT;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lk_reg <= LK_INIT;
      end else if (ce) begin
         lk_reg <= lk_next;
      end
   end

   // ==========================================
   // checks
   msb_first_a: assert property (@(posedge clk) disable iff (!rst_n) // RL17
      (ce && start && !busy) |=> (link.frame && link.sdata == $past(packet[15])))
      else $error("first link bit is not the packet msb");
endmodule : fns_osc_link

//--- verilog/fns_divider_cfg_regs.sv
`timescale 1ns/100ps
// Summary of operation
// RL1: host keeps reference divide in 1..16383
// RL2: fractional mode integer divide 20..7fffc
// RL3: integer mode integer divide 16..7ffff
// RL4: fractional value is unsigned over 2^24
// RL5: port holds id, index, nine data bits
// RL6: each port write launches a link transfer; writes made while the link is busy merge, and only the last is sent
// RL7: port read returns last sent packet
// RL8: start-value select maps to four values
// RL9: start value applied on change with reload
// RL10: order field selects modulator type
// RL11: bypass bit ignores modulator output
// RL12: reload bit reloads start on fraction write
// RL13: clock source ignored when bit10/21 set
// RL14: delay select picks aux or delayed clock
// RL15: core enable picks calibration trigger write
// RL16: self-test start and cycle count lookup
// RL17: packet sent msb first over link
// RL18: link rate never above 50 mhz
// RL19: host zeroes register index before calibration
// RL20: calibration updates only the data field
// RL21: all registers reset to defaults
module fns_divider_cfg_regs import fns_pkg::*; (
   input logic clk,
   input logic rst_n,
   input logic ce,
   input fns_req_s req,
   output logic [23:0] rdata,
   output logic rd_valid,
   input logic cal_data_valid,
   input logic [8:0] cal_data,
   output logic [13:0] ref_divide,
   output logic [18:0] int_divide,
   output logic [23:0] frac_divide,
   output fns_mod_s mod,
   output logic cal_start,
   output logic cal_fractional,
   output fns_link_s link
);
   // ==========================================
   // decoding helpers
   function automatic logic [23:0] seed_value(input logic [1:0] sel);
      case (sel) // RL8
         2'h0: seed_value = FNS_SEED_ZERO;
         2'h1: seed_value = FNS_SEED_LSB;
         2'h2: seed_value = FNS_SEED_A;
         default: seed_value = FNS_SEED_B;
      endcase
   endfunction : seed_value

   function automatic logic [11:0] bist_cycles(input logic [1:0] code);
      case (code) // RL16
         2'h0: bist_cycles = FNS_BIST_C0;
         2'h1: bist_cycles = FNS_BIST_C1;
         2'h2: bist_cycles = FNS_BIST_C2;
         default: bist_cycles = FNS_BIST_C3;
      endcase
   endfunction : bist_cycles

   // static modulator controls decoded from the configuration word
   function automatic fns_mod_s mod_decode(input logic [22:0] cfg, input fns_mod_s prev);
      mod_decode = prev;
      mod_decode.order = fns_order_e'(cfg[FNS_CFG_ORDER_LSB +: 2]); // RL10
      mod_decode.bypass = cfg[FNS_CFG_BYPASS]; // RL11
      if (cfg[FNS_CFG_CLK_DLY] || cfg[FNS_CFG_AUTO_CLK]) begin
         mod_decode.clk_src = FNS_CLK_OVERRIDE; // RL13
      end else begin
         mod_decode.clk_src = cfg[FNS_CFG_CLK_SRC] ? FNS_CLK_OSC : FNS_CLK_REF; // RL13
      end
      mod_decode.clk_delay = cfg[FNS_CFG_CLK_DLY]; // RL14
      mod_decode.core_enable = cfg[FNS_CFG_CORE_EN]; // RL15
      mod_decode.self_test_cycles = bist_cycles(cfg[FNS_CFG_BIST_LSB +: 2]); // RL16
   endfunction : mod_decode

   // ==========================================
   // state
   typedef struct packed {
      logic [13:0] ref_div;
      logic [18:0] int_div;
      logic [23:0] frac_div;
      logic [15:0] port;
      logic [15:0] sent;
      logic pending;
      logic [22:0] mod_cfg;
      logic [23:0] rdata;
      logic rd_valid;
      fns_mod_s mod;
      logic cal_start;
      logic cal_frac;
   } fns_regs_s;

   localparam fns_mod_s MOD_ZERO = '0;
   localparam fns_regs_s R_INIT = '{ // RL21
      ref_div: FNS_RST_REF_DIV, int_div: FNS_RST_INT_DIV, frac_div: FNS_RST_FRAC_DIV,
      port: FNS_RST_OSC_PORT, sent: FNS_RST_OSC_PORT, pending: 1'b0,
      mod_cfg: FNS_RST_MOD_CFG, rdata: 24'h000000, rd_valid: 1'b0,
      mod: mod_decode(FNS_RST_MOD_CFG, MOD_ZERO), cal_start: 1'b0, cal_frac: 1'b0};

   fns_regs_s r_reg;
   fns_regs_s r_next;
   logic link_busy;
   logic launch;

   // the link takes a packet only when idle; later writes overwrite the pending one
   assign launch = r_reg.pending && !link_busy;

   fns_osc_link u_link (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .start(launch),
      .packet(r_reg.port),
      .busy(link_busy),
      .link(link)
   );

   assign rdata = r_reg.rdata;
   assign rd_valid = r_reg.rd_valid;
   assign ref_divide = r_reg.ref_div;
   assign int_divide = r_reg.int_div;
   assign frac_divide = r_reg.frac_div; // RL4
   assign mod = r_reg.mod;
   assign cal_start = r_reg.cal_start;
   assign cal_fractional = r_reg.cal_frac;

   // ==========================================
   // next state
   always_comb begin
      r_next = r_reg;
      r_next.rd_valid = 1'b0;
      r_next.mod.start_load = 1'b0;
      r_next.mod.self_test_start = 1'b0;
      r_next.cal_start = 1'b0;
      if (launch) begin
         r_next.sent = r_reg.port; // RL7
         r_next.pending = 1'b0;
      end
      // calibration touches the data bits only; a host write the same cycle wins
      if (cal_data_valid) begin
         r_next.port[FNS_PORT_DATA_MSB:FNS_PORT_DATA_LSB] = cal_data; // RL20
         r_next.pending = 1'b1; // RL6
      end
      if (req.wr) begin
         case (req.addr)
            FNS_OFF_REF_DIV: r_next.ref_div = req.wdata[13:0];
            FNS_OFF_INT_DIV: begin
               r_next.int_div = req.wdata[18:0];
               if (!r_reg.mod_cfg[FNS_CFG_CORE_EN]) begin
                  r_next.cal_start = 1'b1; // RL15
                  r_next.cal_frac = 1'b0;
               end
            end
            FNS_OFF_FRAC_DIV: begin
               r_next.frac_div = req.wdata;
               if (r_reg.mod_cfg[FNS_CFG_CORE_EN]) begin
                  r_next.cal_start = 1'b1; // RL15
                  r_next.cal_frac = 1'b1;
               end
               // without reload the modulator keeps its running contents
               if (r_reg.mod_cfg[FNS_CFG_RELOAD]) begin
                  r_next.mod.start_value = seed_value(r_reg.mod_cfg[FNS_CFG_SEED_LSB +: 2]); // RL9
                  r_next.mod.start_load = 1'b1; // RL12
               end
            end
            FNS_OFF_OSC_PORT: begin
               r_next.port = req.wdata[15:0]; // RL5
               r_next.pending = 1'b1; // RL6
            end
            FNS_OFF_MOD_CFG: begin
               r_next.mod_cfg = req.wdata[22:0];
               if (req.wdata[FNS_CFG_BIST_EN] && !r_reg.mod_cfg[FNS_CFG_BIST_EN]) begin
                  r_next.mod.self_test_start = 1'b1; // RL16
               end
            end
            default: begin
            end
         endcase
      end
      r_next.mod = mod_decode(r_next.mod_cfg, r_next.mod);
      if (req.rd) begin
         r_next.rd_valid = 1'b1;
         case (req.addr)
            FNS_OFF_REF_DIV: r_next.rdata = {10'h000, r_reg.ref_div};
            FNS_OFF_INT_DIV: r_next.rdata = {5'h00, r_reg.int_div};
            FNS_OFF_FRAC_DIV: r_next.rdata = r_reg.frac_div;
            FNS_OFF_OSC_PORT: r_next.rdata = {8'h00, r_reg.sent}; // RL7
            FNS_OFF_MOD_CFG: r_next.rdata = {1'b0, r_reg.mod_cfg};
            default: r_next.rdata = 24'h000000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= R_INIT; // RL21
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   port_readback_a: assert property ( // RL7
      (ce && req.rd && req.addr == FNS_OFF_OSC_PORT)
      |=> (rd_valid && rdata == {8'h00, $past(r_reg.sent)}))
      else $error("port read does not show last sent packet");

   port_launch_a: assert property ( // RL6
      (ce && req.wr && req.addr == FNS_OFF_OSC_PORT) |-> ##[1:70] $rose(link.frame))
      else $error("port write did not start a link transfer");

   seed_load_a: assert property ( // RL9
      (ce && req.wr && req.addr == FNS_OFF_FRAC_DIV && r_reg.mod_cfg[FNS_CFG_RELOAD])
      |=> (mod.start_load && mod.start_value == seed_value($past(r_reg.mod_cfg[1:0]))))
      else $error("start value not reloaded on fraction write");

   seed_keep_a: assert property ( // RL12
      (ce && req.wr && req.addr == FNS_OFF_FRAC_DIV && !r_reg.mod_cfg[FNS_CFG_RELOAD])
      |=> (!mod.start_load && $stable(mod.start_value)))
      else $error("start value reloaded with reload bit clear");

   clk_override_a: assert property ( // RL13
      (mod.clk_src == FNS_CLK_OSC)
      |-> (r_reg.mod_cfg[FNS_CFG_CLK_SRC] && !r_reg.mod_cfg[FNS_CFG_CLK_DLY]
           && !r_reg.mod_cfg[FNS_CFG_AUTO_CLK]))
      else $error("clock source select not overridden");

   order_map_a: assert property ( // RL10
      mod.order == fns_order_e'(r_reg.mod_cfg[3:2]) && mod.bypass == r_reg.mod_cfg[7])
      else $error("order or bypass does not follow configuration");

   int_cal_a: assert property ( // RL15
      (ce && req.wr && req.addr == FNS_OFF_INT_DIV && !r_reg.mod_cfg[FNS_CFG_CORE_EN])
      |=> (cal_start && !cal_fractional) ##1 (!cal_start || $past(req.wr)))
      else $error("integer write did not start integer calibration");

   self_test_a: assert property ( // RL16
      (ce && req.wr && req.addr == FNS_OFF_MOD_CFG && req.wdata[18] && !r_reg.mod_cfg[18])
      |=> (mod.self_test_start && mod.self_test_cycles == bist_cycles($past(req.wdata[20:19]))))
      else $error("self test start or cycle count wrong");

   cal_field_a: assert property ( // RL20
      (ce && cal_data_valid && !req.wr)
      |=> (r_reg.port[6:0] == $past(r_reg.port[6:0]) && r_reg.port[15:7] == $past(cal_data)))
      else $error("calibration changed id or index field");

   port_write_c: cover property (ce && req.wr && req.addr == FNS_OFF_OSC_PORT ##[1:70] $fell(link.frame));
   seed_load_c: cover property (mod.start_load);
   self_test_c: cover property (mod.self_test_start);
   cal_update_c: cover property (ce && cal_data_valid ##1 $rose(link.frame));
endmodule : fns_divider_cfg_regs

//--- verif/fns_host_model.sv
`timescale 1ns/100ps
module fns_host_model import fns_pkg::*; (
   input logic clk,
   input logic [23:0] rdata,
   input logic rd_valid,
   output fns_req_s req
);
   // ==========================================
   // register port master, driven on the falling edge
   initial req = '0;
   // an idle bus shows inverted address and data, so a stale value never looks live
   task automatic access(input logic wr, input logic [4:0] addr, input logic [23:0] wdata,
         input int gap, output logic [23:0] rd, output logic ok);
      repeat (gap) @(negedge clk);
      @(negedge clk);
      req.wr = wr;
      req.rd = !wr;
      req.addr = addr;
      req.wdata = wdata;
      @(negedge clk);
      ok = rd_valid;
      rd = rdata;
      req.wr = 1'b0;
      req.rd = 1'b0;
      req.addr = ~addr;
      req.wdata = ~wdata;
   endtask : access
   // ==========================================
   // legal host values
   function automatic logic [13:0] legal_ref(input logic [31:0] r);
      return 14'(r % 32'h3fff + 32'h1);
   endfunction : legal_ref
   function automatic logic [18:0] legal_int(input logic [31:0] r, input logic frac);
      return frac ? 19'(r % 32'h7ffe9 + 32'h14) : 19'(r % 32'h7fff0 + 32'h10);
   endfunction : legal_int
endmodule : fns_host_model

//--- verif/fns_divider_cfg_regs_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module fns_divider_cfg_regs_tb import fns_pkg::*; ;
   logic clk;
   logic rst_n;
   logic ce;
   fns_req_s req;
   logic [23:0] rdata;
   logic rd_valid;
   logic cal_data_valid;
   logic [8:0] cal_data;
   logic [13:0] ref_divide;
   logic [18:0] int_divide;
   logic [23:0] frac_divide;
   fns_mod_s mod;
   logic cal_start;
   logic cal_fractional;
   fns_link_s link;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   logic [23:0] exp_reg [2:6] = '{24'h000001, 24'h000019, 24'h000000, 24'h000000, 24'h200b4a};
   logic [23:0] seed_tab [4] = '{24'h000000, 24'h000001, 24'hb29d08, 24'h50f1cd};
   logic [11:0] cyc_tab [4] = '{12'h408, 12'h7ff, 12'hbff, 12'hfff};
   // clock select bits per pass: reference, oscillator, and both overrides
   logic [23:0] clk_tab [4] = '{24'h000000, 24'h000200, 24'h000600, 24'h200200};

   fns_divider_cfg_regs i_dut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .req(req), .rdata(rdata), .rd_valid(rd_valid),
      .cal_data_valid(cal_data_valid), .cal_data(cal_data), .ref_divide(ref_divide),
      .int_divide(int_divide), .frac_divide(frac_divide), .mod(mod), .cal_start(cal_start),
      .cal_fractional(cal_fractional), .link(link));
   fns_host_model i_host (.clk(clk), .rdata(rdata), .rd_valid(rd_valid), .req(req));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ==========================================
   // verdict and hang guard
   task automatic print_verdict();
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         print_verdict();
      end
   end

   // ==========================================
   // host access tasks with a reference copy of the bank
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      logic [23:0] r;
      logic ok;
      i_host.access(1'b1, a, d, $urandom % 3, r, ok);
      case (a)
         5'h02: exp_reg[2] = d & 24'h003fff;
         5'h03: exp_reg[3] = d & 24'h07ffff;
         5'h04: exp_reg[4] = d;
         5'h05: exp_reg[5] = d & 24'h00ffff;
         5'h06: exp_reg[6] = d & 24'h7fffff;
         default: ;
      endcase
   endtask : wr

   task automatic rd(input logic [4:0] a);
      logic [23:0] r;
      logic ok;
      i_host.access(1'b0, a, 24'h000000, $urandom % 3, r, ok);
      `CHK(ok, 1'b1)
      `CHK(r, (a >= 5'h02 && a <= 5'h06) ? exp_reg[a] : 24'h000000)
   endtask : rd

   // a transfer is checked bit by bit from the cycle after launch, two cycles after the launching request
   task automatic chk_link(input logic [15:0] p);
      @(negedge clk);
      for (int i = 15; i >= 0; i--) begin
         `CHK({link.frame, link.sclk, link.sdata}, {2'b10, p[i]})
         @(negedge clk);
         `CHK({link.frame, link.sclk}, 2'b11)
         @(negedge clk);
      end
      `CHK(link, 3'b000)
      exp_reg[5] = {8'h00, p};
   endtask : chk_link

   // ==========================================
   // main sequence
   initial begin
      logic [23:0] cfg;
      logic [15:0] p;
      logic [23:0] r;
      logic ok;
      int unused;
      rst_n = 1'b0;
      ce = 1'b1;
      cal_data_valid = 1'b0;
      cal_data = 9'h000;
      unused = $urandom(616);
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      for (int a = 1; a <= 7; a++) rd(5'(a));
      `CHK({ref_divide, int_divide, frac_divide}, {14'h0001, 19'h00019, 24'h0})
      `CHK({mod.order, mod.clk_src, mod.core_enable}, {2'h2, 2'h2, 1'b1})
      `CHK({mod.self_test_cycles, mod.start_value}, {12'h408, 24'h0})
      repeat (4) begin
         wr(FNS_OFF_REF_DIV, {10'h3ff, i_host.legal_ref($urandom)});
         `CHK(ref_divide, exp_reg[2][13:0])
         wr(FNS_OFF_INT_DIV, {5'h1f, i_host.legal_int($urandom, 1'b1)});
         `CHK({int_divide, cal_start}, {exp_reg[3][18:0], 1'b0})
         wr(FNS_OFF_FRAC_DIV, 24'($urandom));
         `CHK(frac_divide, exp_reg[4])
         wr(5'h1f, 24'($urandom));
         for (int a = 2; a <= 7; a++) rd(5'(a));
      end
      for (int k = 0; k < 4; k++) begin
         cfg = 24'($urandom & 32'h0043f0f0) | clk_tab[k] | 24'h000900 | 24'(k * 5) | (24'(k) << 19);
         wr(FNS_OFF_MOD_CFG, cfg);
         `CHK(mod.order, cfg[3:2])
         `CHK({mod.bypass, mod.clk_delay, mod.core_enable}, {cfg[7], cfg[10], 1'b1})
         `CHK(mod.clk_src, (cfg[10] | cfg[21]) ? 2'h2 : {1'b0, cfg[9]})
         `CHK({mod.self_test_start, mod.self_test_cycles}, {1'b0, cyc_tab[k]})
         wr(FNS_OFF_FRAC_DIV, 24'($urandom));
         `CHK({mod.start_load, mod.start_value}, {1'b1, seed_tab[k]})
         `CHK({cal_start, cal_fractional}, 2'b11)
         @(negedge clk);
         `CHK({mod.start_load, cal_start}, 2'b00)
         wr(FNS_OFF_MOD_CFG, cfg | 24'h040000);
         `CHK(mod.self_test_start, 1'b1)
         wr(FNS_OFF_MOD_CFG, cfg & 24'hfffeff);
         wr(FNS_OFF_FRAC_DIV, 24'($urandom));
         `CHK({mod.start_load, mod.start_value}, {1'b0, seed_tab[k]})
         wr(FNS_OFF_MOD_CFG, cfg & 24'hfff7ff);
         wr(FNS_OFF_INT_DIV, {5'h00, i_host.legal_int($urandom, 1'b0)});
         `CHK({cal_start, cal_fractional, mod.core_enable}, 3'b100)
         rd(FNS_OFF_MOD_CFG);
      end
      // a frozen block takes no request and its outputs hold
      @(negedge clk);
      ce = 1'b0;
      i_host.access(1'b1, FNS_OFF_REF_DIV, {10'h000, i_host.legal_ref($urandom)}, 0, r, ok);
      i_host.access(1'b0, FNS_OFF_REF_DIV, 24'h000000, 0, r, ok);
      `CHK({ok, ref_divide, cal_start}, {1'b0, exp_reg[2][13:0], 1'b0})
      ce = 1'b1;
      p = 16'($urandom);
      wr(FNS_OFF_OSC_PORT, {8'hff, p});
      chk_link(p);
      rd(FNS_OFF_OSC_PORT);
      // index back to zero so calibration data lands in the right place
      p = {p[15:7], 4'h0, p[2:0]};
      wr(FNS_OFF_OSC_PORT, {8'h00, p});
      chk_link(p);
      cal_data = 9'($urandom);
      @(negedge clk);
      cal_data_valid = 1'b1;
      @(negedge clk);
      cal_data_valid = 1'b0;
      chk_link({cal_data, p[6:0]});
      rd(FNS_OFF_OSC_PORT);
      // a reset in mid-run brings every register back to its default
      @(negedge clk);
      rst_n = 1'b0;
      exp_reg = '{24'h000001, 24'h000019, 24'h000000, 24'h000000, 24'h200b4a};
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      for (int a = 2; a <= 6; a++) rd(5'(a));
      `CHK({mod.start_value, link}, {24'h000000, 3'h0})
      print_verdict();
   end
endmodule : fns_divider_cfg_regs_tb
